// ### ptc_pin_src.sv
// Behavioural source of external count clocks and gate levels
`timescale 1ns/100ps
`default_nettype none
module ptc_pin_src (
    // Clock
    input  wire logic       clock,
    // Bench control
    input  wire logic       pinRun,
    input  wire logic [3:0] gateSet,
    // Pins
    output var logic  [3:0] pinClk = 4'h0,
    output var logic  [3:0] gateOut = 4'h0
);
    int phase = 0;
    // Count clock rises every 8 cycles while running and stands low otherwise
    always @(posedge clock) begin
        phase <= pinRun ? phase + 1 : 0;
        pinClk <= (pinRun && phase[2]) ? 4'hF : 4'h0;
        gateOut <= gateSet;
    end
endmodule
`default_nettype wire

// ### ptc_pkg.sv
// Shared constants for the paired timer/counter block
package ptc_pkg;
    // Sizes
    localparam int TIMER_W   = 16;
    localparam int NUM_TIMER = 4;
    localparam int NUM_PAIR  = 2;
    localparam int PRE_W     = 8;
    localparam int PRIO_W    = 3;
    localparam int APB_DW    = 32;

    // Address decode: byte address = timer*16 + register*4
    localparam int ADDR_REG_LSB = 2;
    localparam int ADDR_TIM_LSB = 4;
    localparam int ADDR_TOP_LSB = 6;

    // Register index within one timer's block
    localparam logic [1:0] REG_CON = 2'h0;
    localparam logic [1:0] REG_PER = 2'h1;
    localparam logic [1:0] REG_CNT = 2'h2;
    localparam logic [1:0] REG_IRQ = 2'h3;

    // Control register fields
    localparam int CON_RUN   = 15;
    localparam int CON_SIDL  = 13;
    localparam int CON_GATE  = 6;
    localparam int CON_PS_HI = 5;
    localparam int CON_PS_LO = 4;
    localparam int CON_CASC  = 3;
    localparam int CON_CS    = 1;

    // Writable bits of lower-word and upper-word control registers
    localparam logic [15:0] CON_WMASK_LO = 16'hA07A;
    localparam logic [15:0] CON_WMASK_HI = 16'hA072;

    // Interrupt register fields
    localparam int IRQ_FLAG    = 0;
    localparam int IRQ_EN      = 1;
    localparam int IRQ_PRIO_LO = 2;

    // Reset values
    localparam logic [15:0] CON_RESET = 16'h0000;
    localparam logic [15:0] PER_RESET = 16'hFFFF;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [2:0]  PRIO_RESET = 3'h0;

    // Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
    localparam logic [7:0] PS_TERM_1   = 8'h00;
    localparam logic [7:0] PS_TERM_8   = 8'h07;
    localparam logic [7:0] PS_TERM_64  = 8'h3F;
    localparam logic [7:0] PS_TERM_256 = 8'hFF;
endpackage

// ### ptc_timer_block.sv
// Four 16-bit timers in two cascadable pairs behind an APB slave
`timescale 1ns/100ps
`default_nettype none
//Behaviour
// (R1) The clock-source and gate bits pick plain timing, gated timing, or synchronous counting.
// (R2) Plain and gated timing advance on the internal instruction clock.
// (R3) Synchronous counting advances on rising edges of the external count clock pin.
// (R4) Setting the cascade bit of a lower-word timer joins it and its partner into one 32-bit timer.
// (R5) While cascaded the upper timer holds the high count word and the lower timer the low word.
// (R6) While cascaded only the lower control register steers the pair, save the upper stop-in-idle bit.
// (R7) A cascaded timer signals through the upper timer's flag, enable and priority, not the lower's.
// (R8) The two pairs are timer two with three, and timer four with five.
// (R9) A cascaded timer compares against both period words, upper register high, lower register low.
// (R10) A cascaded timer uses the prescaler field of the lower timer.
// (R11) The running 32-bit count reads as the two count registers, high word in the upper timer.
// (R12) Only timers two and three drive a transfer trigger; timers four and five drive none.
// (R13) Software sets up a 16-bit timer with cascade clear and sets the run bit last.
// (R14) Software sets up a 32-bit timer with cascade set and sets the run bit last.
// (R15) When the count equals the period it returns to zero on the next count event and flags.
// (R16) In gated timing the count advances only while the gate input is high.
module ptc_timer_block
    import ptc_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [APB_DW-1:0]    pwdata,
    output logic      [APB_DW-1:0]    prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Core idle state
    input  wire logic                 idleMode,
    // Pins, one per timer (index 0 is timer two)
    input  wire logic [NUM_TIMER-1:0] externalCountClockPin,
    input  wire logic [NUM_TIMER-1:0] gatePin,
    // Interrupt requests and priorities towards the interrupt controller
    output logic      [NUM_TIMER-1:0] timerIrqReq,
    output logic      [NUM_TIMER*PRIO_W-1:0] timerIrqPriority,
    // Transfer triggers for timers two and three
    output logic      [1:0]           dmaTrigger
);
    // Elaboration check on the address width
    if (ADDR_W <= ADDR_TOP_LSB) begin : gBadAddr
        $error("ADDR_W must exceed the decoded register field");
    end

    logic [TIMER_W-1:0]   con_q [NUM_TIMER];
    logic [TIMER_W-1:0]   per_q [NUM_TIMER];
    logic [TIMER_W-1:0]   cnt   [NUM_TIMER];
    logic [NUM_TIMER-1:0] irqFlag_q;
    logic [NUM_TIMER-1:0] irqEn_q;
    logic [PRIO_W-1:0]    irqPrio_q [NUM_TIMER];
    logic [NUM_TIMER-1:0] match;
    logic [NUM_TIMER-1:0] clkMeta_q;
    logic [NUM_TIMER-1:0] clkSync_q;
    logic [NUM_TIMER-1:0] clkPrev_q;
    logic [NUM_TIMER-1:0] gateMeta_q;
    logic [NUM_TIMER-1:0] gateSync_q;
    logic [NUM_TIMER-1:0] clkRise;
    logic [NUM_TIMER-1:0] evt;
    logic [NUM_TIMER-1:0] runEff;
    logic [NUM_TIMER-1:0] cascOf;
    logic [NUM_TIMER-1:0] wrCnt;
    logic                 wordOk;
    logic [1:0]           timSel;
    logic [1:0]           regSel;
    logic                 wrEn;
    logic [APB_DW-1:0]    rdMux;
    logic [APB_DW-1:0]    prdata_q;
    logic                 err_q;

    // Two-stage synchronisers for the pins, then a delay for edge finding
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            clkMeta_q  <= '0;
            clkSync_q  <= '0;
            clkPrev_q  <= '0;
            gateMeta_q <= '0;
            gateSync_q <= '0;
        end else begin
            clkMeta_q  <= externalCountClockPin;
            clkSync_q  <= clkMeta_q;
            clkPrev_q  <= clkSync_q;
            gateMeta_q <= gatePin;
            gateSync_q <= gateMeta_q;
        end
    end

    assign clkRise = clkSync_q & ~clkPrev_q;

    // Count event and run qualification for each timer
    always_comb begin
        for (int i = 0; i < NUM_TIMER; i++) begin
            cascOf[i] = con_q[i & ~1][CON_CASC]; // (R8)
            if (con_q[i][CON_CS]) begin // (R1)
                evt[i] = clkRise[i]; // (R3)
            end else if (con_q[i][CON_GATE]) begin
                evt[i] = gateSync_q[i]; // (R16)
            end else begin
                evt[i] = 1'b1; // (R2)
            end
            // Upper stop-in-idle still halts a cascaded pair
            runEff[i] = con_q[i][CON_RUN] & ~(idleMode & (con_q[i][CON_SIDL]
                        | ((i % 2 == 0) & cascOf[i] & con_q[i | 1][CON_SIDL]))); // (R6)
        end
    end

    // The two cascadable pairs
    for (genvar p = 0; p < NUM_PAIR; p++) begin : gPair
        ptc_timer_pair uPair (
            .clock    (clock),
            .rst_n    (rst_n),
            .runLo    (runEff[2*p]),
            .runHi    (runEff[2*p+1]),
            .evtLo    (evt[2*p]),
            .evtHi    (evt[2*p+1]),
            .psLo     (con_q[2*p][CON_PS_HI:CON_PS_LO]),
            .psHi     (con_q[2*p+1][CON_PS_HI:CON_PS_LO]),
            .cascade  (con_q[2*p][CON_CASC]), // (R4)
            .periodLo (per_q[2*p]),
            .periodHi (per_q[2*p+1]),
            .wrCntLo  (wrCnt[2*p]),
            .wrCntHi  (wrCnt[2*p+1]),
            .wrData   (pwdata[TIMER_W-1:0]),
            .countLo  (cnt[2*p]),
            .countHi  (cnt[2*p+1]),
            .matchLo  (match[2*p]),
            .matchHi  (match[2*p+1])
        );
    end

    // APB decode: every aligned word below the top field is mapped
    assign wordOk = (paddr[ADDR_REG_LSB-1:0] == '0) && (paddr[ADDR_W-1:ADDR_TOP_LSB] == '0);
    assign timSel = paddr[ADDR_TOP_LSB-1:ADDR_TIM_LSB];
    assign regSel = paddr[ADDR_TIM_LSB-1:ADDR_REG_LSB];
    assign wrEn   = psel & penable & pwrite & wordOk;

    // Count writes go straight into the pair
    always_comb begin
        for (int i = 0; i < NUM_TIMER; i++) begin
            wrCnt[i] = wrEn && (timSel == 2'(i)) && (regSel == REG_CNT);
        end
    end

    // Control and period registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_TIMER; i++) begin
                con_q[i] <= CON_RESET;
                per_q[i] <= PER_RESET;
            end
        end else if (wrEn) begin
            for (int i = 0; i < NUM_TIMER; i++) begin
                if (timSel == 2'(i) && regSel == REG_CON) begin
                    // Cascade bit exists only in lower-word timers
                    con_q[i] <= pwdata[TIMER_W-1:0]
                                & ((i % 2 == 0) ? CON_WMASK_LO : CON_WMASK_HI);
                end
                if (timSel == 2'(i) && regSel == REG_PER) begin
                    per_q[i] <= pwdata[TIMER_W-1:0];
                end
            end
        end
    end

    // Interrupt flags: a match in the same cycle as a clear wins
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irqFlag_q <= '0;
            irqEn_q   <= '0;
            for (int i = 0; i < NUM_TIMER; i++) begin
                irqPrio_q[i] <= PRIO_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_TIMER; i++) begin
                if (wrEn && timSel == 2'(i) && regSel == REG_IRQ) begin
                    irqFlag_q[i] <= match[i] | pwdata[IRQ_FLAG]; // (R15)
                    irqEn_q[i]   <= pwdata[IRQ_EN];
                    irqPrio_q[i] <= pwdata[IRQ_PRIO_LO +: PRIO_W];
                end else if (match[i]) begin
                    irqFlag_q[i] <= 1'b1; // (R15)
                end
            end
        end
    end

    // Requests; the lower timer of a cascaded pair is silenced
    always_comb begin
        for (int i = 0; i < NUM_TIMER; i++) begin
            timerIrqReq[i] = irqFlag_q[i] & irqEn_q[i]
                             & ~((i % 2 == 0) & cascOf[i]); // (R7)
            timerIrqPriority[i*PRIO_W +: PRIO_W] = irqPrio_q[i]; // (R7)
        end
    end

    // Triggers from the first pair only
    assign dmaTrigger = {match[1], match[0]}; // (R12)

    // Read multiplexer
    always_comb begin
        rdMux = '0;
        unique case (regSel)
            REG_CON: rdMux[TIMER_W-1:0] = con_q[timSel];
            REG_PER: rdMux[TIMER_W-1:0] = per_q[timSel];
            REG_CNT: rdMux[TIMER_W-1:0] = cnt[timSel]; // (R11)
            REG_IRQ: rdMux[IRQ_PRIO_LO+PRIO_W-1:0] =
                     {irqPrio_q[timSel], irqEn_q[timSel], irqFlag_q[timSel]};
        endcase
        if (!wordOk) begin
            rdMux = '0;
        end
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prdata_q <= '0;
            err_q    <= 1'b0;
        end else if (psel & ~penable) begin
            prdata_q <= pwrite ? '0 : rdMux;
            err_q    <= ~wordOk;
        end
    end

    // Zero-wait-state answer
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = err_q & psel & penable;
endmodule
`default_nettype wire

// ### ptc_timer_checker.sv
// Port-level assertions for the paired timer block
`timescale 1ns/100ps
`default_nettype none
module ptc_timer_checker
    import ptc_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    // Clock and reset
    input wire logic                  clock,
    input wire logic                  rst_n,
    // APB
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_W-1:0]     paddr,
    input wire logic [APB_DW-1:0]     pwdata,
    input wire logic [APB_DW-1:0]     prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Pins and requests
    input wire logic                  idleMode,
    input wire logic [NUM_TIMER-1:0]  externalCountClockPin,
    input wire logic [NUM_TIMER-1:0]  gatePin,
    input wire logic [NUM_TIMER-1:0]  timerIrqReq,
    input wire logic [NUM_TIMER*PRIO_W-1:0] timerIrqPriority,
    input wire logic [1:0]            dmaTrigger
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Decode helpers
    wire logic unmapped = (paddr[ADDR_REG_LSB-1:0] != '0)
                          || (paddr[ADDR_W-1:ADDR_TOP_LSB] != '0);
    wire logic wrAcc = psel && penable && pwrite;
    sequence s_access; psel && penable; endsequence
    sequence s_read; psel && !penable && !pwrite ##1 psel && penable; endsequence

    a_ready_high: assert property (pready) else $error("pready low");
    a_err_decode: assert property (s_access |-> pslverr == unmapped)
        else $error("pslverr does not follow decode");
    a_err_idle: assert property (!(psel && penable) |-> !pslverr)
        else $error("pslverr outside access");
    a_unmapped_zero: assert property (s_access ##0 unmapped |-> prdata == '0)
        else $error("unmapped read data not zero");
    a_write_zero: assert property (s_access ##0 pwrite |-> prdata == '0)
        else $error("read data not zero on write");
    a_read_hold: assert property (s_read |=> $stable(prdata))
        else $error("read data moved after access");
    a_irq_cause: assert property ($rose(timerIrqReq[1])
        |-> $past(dmaTrigger[1]) || $past(wrAcc))
        else $error("upper request rose without match or write");
    a_prio_write: assert property (!$stable(timerIrqPriority) |-> $past(wrAcc))
        else $error("priority changed without write");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !timerIrqReq && !dmaTrigger && !pslverr)
        else $error("outputs active after reset edge");
endmodule
bind ptc_timer_block ptc_timer_checker #(.ADDR_W(ADDR_W)) checker0 (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idleMode(idleMode), .externalCountClockPin(externalCountClockPin), .gatePin(gatePin),
    .timerIrqReq(timerIrqReq), .timerIrqPriority(timerIrqPriority), .dmaTrigger(dmaTrigger)
);
`default_nettype wire

// ### ptc_timer_pair.sv
// One cascadable pair of 16-bit timers with prescalers
`timescale 1ns/100ps
`default_nettype none
module ptc_timer_pair
    import ptc_pkg::*;
(
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               rst_n,
    // Run and count events per half
    input  wire logic               runLo,
    input  wire logic               runHi,
    input  wire logic               evtLo,
    input  wire logic               evtHi,
    // Configuration
    input  wire logic [1:0]         psLo,
    input  wire logic [1:0]         psHi,
    input  wire logic               cascade,
    input  wire logic [TIMER_W-1:0] periodLo,
    input  wire logic [TIMER_W-1:0] periodHi,
    // Count writes from software
    input  wire logic               wrCntLo,
    input  wire logic               wrCntHi,
    input  wire logic [TIMER_W-1:0] wrData,
    // Count and period-match results
    output logic [TIMER_W-1:0]      countLo,
    output logic [TIMER_W-1:0]      countHi,
    output logic                    matchLo,
    output logic                    matchHi
);
    logic [PRE_W-1:0]     preLo_q;
    logic [PRE_W-1:0]     preHi_q;
    logic                 tickLo;
    logic                 tickHi;
    logic [2*TIMER_W-1:0] cnt32;
    logic [2*TIMER_W-1:0] per32;
    logic [2*TIMER_W-1:0] nxt32;
    logic                 eq32;

    // Terminal count of the prescaler for a ratio field
    function automatic logic [PRE_W-1:0] preTerm(input logic [1:0] ps);
        case (ps)
            2'h0:    preTerm = PS_TERM_1;
            2'h1:    preTerm = PS_TERM_8;
            2'h2:    preTerm = PS_TERM_64;
            default: preTerm = PS_TERM_256;
        endcase
    endfunction

    // Prescaled ticks; upper half is idle while cascaded
    assign tickLo = runLo & evtLo & (preLo_q == preTerm(psLo)); // (R10)
    assign tickHi = ~cascade & runHi & evtHi & (preHi_q == preTerm(psHi)); // (R6)

    // 32-bit view of the pair
    assign cnt32 = {countHi, countLo}; // (R5)
    assign per32 = {periodHi, periodLo}; // (R9)
    assign eq32  = (cnt32 == per32);
    assign nxt32 = eq32 ? '0 : cnt32 + 32'h0000_0001;

    // Lower prescaler
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            preLo_q <= '0;
        end else if (runLo & evtLo) begin
            preLo_q <= tickLo ? '0 : preLo_q + 8'h01;
        end
    end

    // Upper prescaler
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            preHi_q <= '0;
        end else if (cascade) begin
            preHi_q <= '0;
        end else if (runHi & evtHi) begin
            preHi_q <= tickHi ? '0 : preHi_q + 8'h01;
        end
    end

    // Lower count word: wraps to zero on the tick after a period match
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            countLo <= CNT_RESET;
        end else if (wrCntLo) begin
            countLo <= wrData;
        end else if (tickLo & cascade) begin
            countLo <= nxt32[TIMER_W-1:0]; // (R4)
        end else if (tickLo) begin
            countLo <= (countLo == periodLo) ? '0 : countLo + 16'h0001; // (R15)
        end
    end

    // Upper count word: carries the high half while cascaded
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            countHi <= CNT_RESET;
        end else if (wrCntHi) begin
            countHi <= wrData;
        end else if (tickLo & cascade) begin
            countHi <= nxt32[2*TIMER_W-1:TIMER_W]; // (R5)
        end else if (tickHi) begin
            countHi <= (countHi == periodHi) ? '0 : countHi + 16'h0001; // (R15)
        end
    end

    // Match pulses; a cascaded match shows on the upper half only
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            matchLo <= 1'b0;
            matchHi <= 1'b0;
        end else begin
            matchLo <= tickLo & ~cascade & (countLo == periodLo);
            matchHi <= cascade ? (tickLo & eq32) : (tickHi & (countHi == periodHi)); // (R7)
        end
    end
endmodule
`default_nettype wire

// ### tb_ptc_timer_block.sv
// Self-checking bench for the paired timer block
`timescale 1ns/100ps
`default_nettype none
module tb_ptc_timer_block
    import ptc_pkg::*;
;
    // Bench signals
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pinRun = 1'b0;
    logic [3:0]  gateSet = 4'h0;
    logic [3:0]  pinClk;
    logic [3:0]  gateOut;
    logic [3:0]  irqReq;
    logic [11:0] irqPrio;
    logic [1:0]  dmaTrig;
    logic        idleMode = 1'b0;
    logic [31:0] lfsrQ = 32'h00016656;
    logic [32:0] expQ[$];
    int          errCount = 0;
    int          checksDone = 0;
    int          cycles = 0;

    // 10 MHz clock
    always #50 clock = ~clock;

    ptc_timer_block #(.ADDR_W(8)) dut (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .idleMode(idleMode), .externalCountClockPin(pinClk), .gatePin(gateOut),
        .timerIrqReq(irqReq), .timerIrqPriority(irqPrio), .dmaTrigger(dmaTrig)
    );
    ptc_pin_src partner (
        .clock(clock), .pinRun(pinRun), .gateSet(gateSet), .pinClk(pinClk), .gateOut(gateOut)
    );

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errCount++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finalReport();
        $display("checks=%0d mismatches=%0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic logic [7:0] ra(input int t, input logic [1:0] r);
        return {2'h0, t[1:0], r, 2'h0};
    endfunction

    // Next value of the 32-bit random source
    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // Read notes {pslverr, prdata} expected
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        expQ.push_back(e);
        apb(1'b0, a, 32'h00000000);
    endtask

    task automatic startTimer(input int t, input logic [31:0] per, input logic [31:0] con);
        wr(ra(t, REG_CNT), 32'h00000000);
        wr(ra(t, REG_PER), per);
        wr(ra(t, REG_CON), con);
    endtask

    // Cycles until the next match pulse, capped at 2000
    task automatic waitPulse(input int b, output int n);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (dmaTrig[b] !== 1'b1 && n < 2000);
    endtask

    // Compare each read answer with the oldest note
    always @(posedge clock) begin
        if (psel && penable && pready && !pwrite && expQ.size() > 0)
            check({pslverr, prdata}, expQ.pop_front());
    end

    // Hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            errCount++;
            finalReport();
        end
    end

    initial begin
        int n;
        int perT[4] = '{4, 2, 1, 1};
        int gapT[4] = '{5, 24, 128, 512};
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        // Reset values, write masks and random count loads
        for (int t = 0; t < 4; t++) begin
            rd(ra(t, REG_CON), 33'h000000000);
            rd(ra(t, REG_PER), {17'h00000, PER_RESET});
            wr(ra(t, REG_CON), 32'hFFFF7FFF);
            rd(ra(t, REG_CON), {17'h00000, (t[0] ? CON_WMASK_HI : CON_WMASK_LO) & 16'h7FFF});
            wr(ra(t, REG_CON), 32'h00000000);
            lfsrQ = lfsrNext(lfsrQ);
            wr(ra(t, REG_CNT), lfsrQ);
            rd(ra(t, REG_CNT), {17'h00000, lfsrQ[15:0]});
        end
        rd(8'h41, 33'h100000000);
        rd(8'h06, 33'h100000000);
        rd(8'h80, 33'h100000000);
        // Every prescale code in plain timing
        for (int i = 0; i < 4; i++) begin
            startTimer(0, perT[i], 32'h00008000 | (i << 4));
            waitPulse(0, n);
            waitPulse(0, n);
            check(33'(n), 33'(gapT[i]));
            wr(ra(0, REG_CON), 32'h00000000);
        end
        // Gated timing holds while gate low
        startTimer(0, 32'h00000003, 32'h00008040);
        waitPulse(0, n);
        check(33'(n), 33'd2000);
        gateSet <= 4'h1;
        waitPulse(0, n);
        waitPulse(0, n);
        check(33'(n), 33'd4);
        // Synchronous counting from the pin, gate ignored
        gateSet <= 4'h0;
        pinRun <= 1'b1;
        startTimer(0, 32'h00000001, 32'h00008042);
        waitPulse(0, n);
        waitPulse(0, n);
        check(33'(n), 33'd16);
        pinRun <= 1'b0;
        wr(ra(0, REG_CON), 32'h00000000);
        // Cascaded pair: upper word of period matters
        wr(ra(1, REG_CON), 32'h00000072);
        wr(ra(0, REG_PER), 32'h00000003);
        wr(ra(1, REG_PER), 32'h00000001);
        wr(ra(0, REG_CNT), 32'h00000002);
        wr(ra(1, REG_CNT), 32'h00000000);
        wr(ra(0, REG_IRQ), 32'h00000002);
        wr(ra(1, REG_IRQ), 32'h00000016);
        wr(ra(0, REG_CON), 32'h00008008);
        waitPulse(1, n);
        check(33'(n), 33'd2000);
        wr(ra(0, REG_CON), 32'h00000008);
        wr(ra(0, REG_CNT), 32'h00000000);
        wr(ra(1, REG_CNT), 32'h00000001);
        rd(ra(1, REG_CNT), 33'h000000001);
        wr(ra(0, REG_CON), 32'h00008008);
        // Three ticks to the period, one to wrap, one for the match pulse
        waitPulse(1, n);
        check(33'(n), 33'd5);
        wr(ra(0, REG_CON), 32'h00000008);
        rd(ra(1, REG_CNT), 33'h000000000);
        rd(ra(1, REG_IRQ), 33'h000000017);
        rd(ra(0, REG_IRQ), 33'h000000002);
        check({29'h0, irqReq}, 33'h2);
        check({21'h0, irqPrio}, 33'h028);
        // Upper stop-in-idle halts a cascaded pair while idle
        idleMode <= 1'b1;
        wr(ra(1, REG_CON), 32'h00002072);
        wr(ra(0, REG_CNT), 32'h00000000);
        wr(ra(0, REG_CON), 32'h00008008);
        rd(ra(0, REG_CNT), 33'h000000000);
        rd(ra(1, REG_CNT), 33'h000000000);
        idleMode <= 1'b0;
        finalReport();
    end
endmodule
`default_nettype wire
